// ==== verilog/pdr_cfg.svh ====
// Constants for the power-down and reset block
// Assumes inclusion by bare name from verilog/ files
`ifndef PDR_CFG_SVH
`define PDR_CFG_SVH
// ==========================================
// Timing
`define PDR_CLK_PERIOD_NS 10
`define PDR_RESET_MIN_NS 100
`define PDR_XPDLL_NS 24
`define PDR_XPDLL_MIN_CK 10
`define PDR_CPDED_CK 1
`define PDR_XP_CK 3
`define PDR_ANPD_CK 2
// ==========================================
// Command encoding {cs_n, ras_n, cas_n, we_n}
`define PDR_CMD_NOP 4'h7
`define PDR_CMD_ACT 4'h3
`define PDR_CMD_PRE 4'h2
`define PDR_CMD_RD 4'h5
`define PDR_CMD_WR 4'h4
`define PDR_CMD_REF 4'h1
`define PDR_CMD_MRS 4'h0
`define PDR_CS_BIT 3
`define PDR_PRE_ALL_BIT 10
`define PDR_EXIT_SEL_BIT 12
`define PDR_DLL_RST_BIT 8
// Pin levels out of system reset: {odt, reset_n, cke} = low, high, low
`define PDR_SYNC_RESET 3'h2
`define PDR_MR_NONE 3'h0
`define PDR_NBANK 8
`endif

// ==== verilog/pdr_pkg.sv ====
// Types for the power-down and reset block
// Assumes pdr_cfg.svh for numeric constants
`default_nettype none
package pdr_pkg;
   // ==========================================
   // Power state, one-hot
   typedef enum logic [4:0]
   {
      pdr_st_reset = 5'h01,
      pdr_st_run = 5'h02,
      pdr_st_act_pd = 5'h04,
      pdr_st_pre_fast = 5'h08,
      pdr_st_pre_slow = 5'h10
   } pdr_state_t;
endpackage
`default_nettype wire

// ==== verilog/pdr_sync_if.sv ====
// Interface carrying synchronised pin levels
// Assumes a single clk_sys domain
`timescale 1ns/1ns
`default_nettype none
interface pdr_sync_if;
   logic cke;
   logic reset_pin_n;
   logic odt;
   modport src (output cke, reset_pin_n, odt);
   modport dst (input cke, reset_pin_n, odt);
endinterface
`default_nettype wire

// ==== verilog/pdr_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
// Assumes pins are asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "pdr_cfg.svh"
module pdr_pin_sync
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic cke_pin,
   input wire logic reset_pin_n,
   input wire logic odt_pin,
   pdr_sync_if.src sync
);
   // ==========================================
   // Synchroniser chains
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] held;
   logic [2:0] next_held;
   // Hold old value until stages two and three agree
   assign next_held = (s2 & s3) | (held & (s2 | s3));
   assign sync.cke = held[0];
   assign sync.reset_pin_n = held[1];
   assign sync.odt = held[2];
   // Chain registers; reset to deasserted pin levels
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         s1 <= `PDR_SYNC_RESET;
         s2 <= `PDR_SYNC_RESET;
         s3 <= `PDR_SYNC_RESET;
         held <= `PDR_SYNC_RESET;
      end
      else if (ce)
      begin
         s1 <= {odt_pin, reset_pin_n, cke_pin};
         s2 <= s1;
         s3 <= s2;
         held <= next_held;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/pdr_top.sv ====
// Power-down entry/exit and reset logic of a DDR3 memory device
// Assumes controller drives pins; clk_sys stands in for the command clock
`timescale 1ns/1ns
`default_nettype none
`include "pdr_cfg.svh"
// Behaviour
// - Enter power-down when CKE sampled low with NOP or deselect.
// - Entry gates all buffers except clock, ODT, CKE, reset; NOPs till settled.
// - Open bank gives active power-down, all closed gives precharge power-down.
// - Exit speed bit 1 keeps DLL on; 0 switches it off.
// - DLL stays on in active power-down; exit always fast.
// - Reset low during power-down leaves it into reset state.
// - Exit when CKE sampled high with NOP; controller holds tCKE.
// - Slow-exit ODT asynchronous from entry to tANPD plus tXPDLL after exit.
// - Reset input acts whenever it goes low.
// - Reset held 100ns; outputs off, termination high impedance.
// - Reset clears all counters but refresh counters.
module pdr_top
   import pdr_pkg::*;
#(
   parameter int NBANK = `PDR_NBANK
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic cke_pin,
   input wire logic reset_pin_n,
   input wire logic odt_pin,
   input wire logic [3:0] cmd,
   input wire logic [2:0] bank_addr,
   input wire logic [12:0] addr,
   input wire logic [2:0] mr_sel,
   output pdr_pkg::pdr_state_t state,
   output logic in_power_down,
   output logic buffers_on,
   output logic dll_on,
   output logic odt_async,
   output logic outputs_enabled,
   output logic term_enabled,
   output logic dll_reset_needed,
   output logic [NBANK-1:0] bank_open,
   output logic [15:0] refresh_count
);
   import pdr_pkg::*;
   localparam int XPDLL_NS_CK = (`PDR_XPDLL_NS + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS;
   localparam int XPDLL_CK = XPDLL_NS_CK > `PDR_XPDLL_MIN_CK ? XPDLL_NS_CK : `PDR_XPDLL_MIN_CK;
   localparam int RST_CK = (`PDR_RESET_MIN_NS + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS;
   localparam int ASYNC_CK = `PDR_ANPD_CK + XPDLL_CK;

   // ==========================================
   // Synchronised pins
   pdr_sync_if sync ();
   pdr_pin_sync pdr_pin_sync_inst
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .cke_pin(cke_pin),
      .reset_pin_n(reset_pin_n),
      .odt_pin(odt_pin),
      .sync(sync)
   );

   // ==========================================
   // Command decode
   wire logic is_nop = cmd[`PDR_CS_BIT] || cmd == `PDR_CMD_NOP;
   wire logic is_act = cmd == `PDR_CMD_ACT;
   wire logic is_pre = cmd == `PDR_CMD_PRE;
   wire logic pre_all = is_pre && addr[`PDR_PRE_ALL_BIT];
   wire logic is_mrs = cmd == `PDR_CMD_MRS;
   wire logic is_ref = cmd == `PDR_CMD_REF;
   wire logic mr0_write = is_mrs && mr_sel == `PDR_MR_NONE;
   wire logic running = state == pdr_st_run;
   wire logic in_pd = state == pdr_st_act_pd || state == pdr_st_pre_fast || state == pdr_st_pre_slow;
   wire logic enter = running && !sync.cke && is_nop;
   wire logic leave = in_pd && sync.cke && is_nop;
   wire logic reset_low = !sync.reset_pin_n;
   // Command gate: commands are taken only in running state with CKE high
   wire logic cmd_ok = running && sync.cke && ce;

   // ==========================================
   // Exit speed and DLL tracking
   logic exit_fast;
   logic [5:0] async_cnt;
   logic [3:0] cpded_cnt;
   logic [7:0] rst_cnt;
   pdr_state_t next_state;

   // Open bank selects active, else the exit-speed bit picks fast or slow
   always_comb
   begin
      next_state = state;
      if (reset_low)
         next_state = pdr_st_reset;
      else if (state == pdr_st_reset)
      begin
         if (rst_cnt >= 8'(RST_CK))
            next_state = pdr_st_run;
      end
      else if (enter)
      begin
         if (|bank_open)
            next_state = pdr_st_act_pd;
         else if (exit_fast)
            next_state = pdr_st_pre_fast;
         else
            next_state = pdr_st_pre_slow;
      end
      else if (leave)
         next_state = pdr_st_run;
   end

   // State, output flags and counters
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state <= pdr_st_reset;
         in_power_down <= 1'b0;
         buffers_on <= 1'b0;
         dll_on <= 1'b0;
         odt_async <= 1'b0;
         outputs_enabled <= 1'b0;
         term_enabled <= 1'b0;
         dll_reset_needed <= 1'b0;
         exit_fast <= 1'b0;
         async_cnt <= 6'h00;
         cpded_cnt <= 4'h0;
         rst_cnt <= 8'h00;
      end
      else if (ce)
      begin
         state <= next_state;
         in_power_down <= next_state != pdr_st_run && next_state != pdr_st_reset;
         // Reset turns off drivers and termination at once
         outputs_enabled <= next_state == pdr_st_run;
         term_enabled <= next_state != pdr_st_reset && sync.odt;
         // Counters other than refresh cleared in reset
         rst_cnt <= state == pdr_st_reset ? rst_cnt + ((rst_cnt < 8'(RST_CK)) ? 8'h01 : 8'h00) : 8'h00;
         if (mr0_write && cmd_ok)
            exit_fast <= addr[`PDR_EXIT_SEL_BIT];
         // DLL off in reset and in slow precharge power-down
         dll_on <= next_state != pdr_st_reset && next_state != pdr_st_pre_slow;
         if (state == pdr_st_pre_slow && leave)
            dll_reset_needed <= 1'b0;
         else if (next_state == pdr_st_reset)
            dll_reset_needed <= 1'b1;
         else if (mr0_write && cmd_ok && addr[`PDR_DLL_RST_BIT])
            dll_reset_needed <= 1'b0;
         // Buffers gated a settle time after entry count dropped by reset
         if (next_state == pdr_st_reset)
            cpded_cnt <= 4'h0;
         else if (enter)
            cpded_cnt <= 4'(`PDR_CPDED_CK);
         else if (cpded_cnt != 4'h0)
            cpded_cnt <= cpded_cnt - 4'h1;
         buffers_on <= !(in_pd && cpded_cnt == 4'h0) && next_state != pdr_st_reset;
         // Async ODT window around slow precharge power-down
         if (next_state == pdr_st_pre_slow || next_state == pdr_st_reset)
            async_cnt <= next_state == pdr_st_reset ? 6'h00 : 6'(ASYNC_CK);
         else if (async_cnt != 6'h00)
            async_cnt <= async_cnt - 6'h01;
         odt_async <= next_state == pdr_st_pre_slow || (next_state == pdr_st_run && async_cnt > 6'h01);
      end
   end

   // ==========================================
   // Bank tracking (cleared by reset) and refresh counter (kept over reset)
   genvar gb;
   generate
      for (gb = 0; gb < NBANK; gb++)
      begin : g_bank
         always_ff @(posedge clk_sys)
         begin
            if (!resetn)
               bank_open[gb] <= 1'b0;
            else if (ce && reset_low)
               bank_open[gb] <= 1'b0;
            else if (cmd_ok && is_act && bank_addr == 3'(gb))
               bank_open[gb] <= 1'b1;
            else if (cmd_ok && (pre_all || (is_pre && bank_addr == 3'(gb))))
               bank_open[gb] <= 1'b0;
         end
      end
   endgenerate

   // Refresh counter survives the reset pin
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         refresh_count <= 16'h0000;
      else if (cmd_ok && is_ref)
         refresh_count <= refresh_count + 16'h0001;
   end

   // ==========================================
   // Checks
   a_entry_on_nop: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && running && !sync.cke && is_nop && sync.reset_pin_n) |=> in_power_down)
      else $error("power-down not entered");
   a_active_kind: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && enter && |bank_open && sync.reset_pin_n) |=> state == pdr_st_act_pd)
      else $error("open bank not active power-down");
   a_slow_dll_off: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == pdr_st_pre_slow) |-> !dll_on)
      else $error("DLL on in slow power-down");
   a_active_dll_on: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == pdr_st_act_pd) |-> dll_on)
      else $error("DLL off in active power-down");
   a_reset_exits_pd: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && in_pd && reset_low) |=> state == pdr_st_reset && !in_power_down)
      else $error("reset did not leave power-down");
   a_exit_on_cke: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && leave && sync.reset_pin_n) |=> running && !in_power_down)
      else $error("power-down exit missed");
   a_async_odt_slow: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == pdr_st_pre_slow) |-> odt_async)
      else $error("ODT not async in slow power-down");
   a_reset_outputs: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && reset_low) |=> !outputs_enabled && !term_enabled)
      else $error("outputs on during reset");
   a_reset_counter: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && reset_low && state != pdr_st_reset) |=> rst_cnt == 8'h00 && cpded_cnt == 4'h0 && async_cnt == 6'h00)
      else $error("reset counter not cleared");
   a_bank_cleared: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ce && reset_low) |=> bank_open == '0)
      else $error("banks not cleared");
endmodule
`default_nettype wire

// ==== verif/pdr_ctl_model.sv ====
// Controller model driving the pin side of pdr_top
// Assumes clk_sys stands in for CK; pins change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module pdr_ctl_model
#(
   parameter int SYNC_CK = 4,
   parameter int XP_CK = 3,
   parameter int PD_MIN_CK = 4,
   parameter int RST_CK = 10,
   parameter int WL_CK = 5,
   parameter int WR_CK = 6,
   parameter int RFC_CK = 11
)
(
   input wire logic clk_sys,
   output logic cke_pin,
   output logic reset_pin_n,
   output logic odt_pin,
   output logic [3:0] cmd,
   output logic [2:0] bank_addr,
   output logic [12:0] addr,
   output logic [2:0] mr_sel
);
   // CKE stays high after exit long enough to cover a refresh still running
   localparam int HOLD_CK = XP_CK > RFC_CK ? XP_CK : RFC_CK;
   // ======================
   // Idle levels: deselected, ODT held valid
   initial
   begin
      cke_pin = 1'b1;
      reset_pin_n = 1'b1;
      odt_pin = 1'b1;
      cmd = 4'hf;
      bank_addr = 3'h0;
      addr = 13'h0;
      mr_sel = 3'h0;
   end
   // One command; unselected lines then show inverted values
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a, input int delay_ck);
      @(negedge clk_sys);
      cmd = c;
      bank_addr = b;
      addr = a;
      mr_sel = 3'h0;
      @(negedge clk_sys);
      cmd = 4'hf;
      bank_addr = ~b;
      addr = ~a;
      mr_sel = 3'h7;
      repeat (delay_ck) @(negedge clk_sys);
   endtask
   // CKE low with deselect, held for the minimum low time
   task automatic enter_pd();
      @(negedge clk_sys);
      cke_pin = 1'b0;
      repeat (SYNC_CK + PD_MIN_CK) @(negedge clk_sys);
   endtask
   // CKE high; nothing valid until sync path, exit latency and any refresh pass
   task automatic exit_pd();
      @(negedge clk_sys);
      cke_pin = 1'b1;
      repeat (SYNC_CK + HOLD_CK) @(negedge clk_sys);
   endtask
   // Write, then WL, burst tail (2 if chop fixed), recovery, one more with autoclose
   task automatic write_then_wait(input logic [2:0] b, input logic chop_fixed, input logic autoclose);
      int gap;
      gap = WL_CK + (chop_fixed ? 2 : 4) + WR_CK + (autoclose ? 1 : 0);
      issue(4'h4, b, {2'h0, autoclose, 10'h000}, gap);
   endtask
   // Reset pulse of minimum width, CKE low before release
   task automatic pin_reset();
      @(negedge clk_sys);
      reset_pin_n = 1'b0;
      repeat (RST_CK) @(negedge clk_sys);
      cke_pin = 1'b0;
      @(negedge clk_sys);
      reset_pin_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== verif/pdr_top_test.sv ====
// Self-checking bench for pdr_top
// Assumes pdr_ctl_model drives every pin-side input
`timescale 1ns/1ns
`default_nettype none
module pdr_top_test;
   import pdr_pkg::*;
   logic clk_sys, resetn, ce, cke_pin, reset_pin_n, odt_pin;
   logic [3:0] cmd;
   logic [2:0] bank_addr, mr_sel;
   logic [12:0] addr;
   pdr_state_t state;
   logic in_power_down, buffers_on, dll_on, odt_async, outputs_enabled, term_enabled, dll_reset_needed;
   logic [7:0] bank_open;
   logic [15:0] refresh_count;
   int mismatches = 0;
   int total_checks = 0;
   // ======================
   // Clock, reset and instances
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      resetn = 1'b0;
      ce = 1'b1; // Held high except in the freeze check
   end
   pdr_top #(.NBANK(8)) pdr_top_inst (.clk_sys, .resetn, .ce, .cke_pin, .reset_pin_n, .odt_pin, .cmd,
      .bank_addr, .addr, .mr_sel, .state, .in_power_down, .buffers_on, .dll_on, .odt_async,
      .outputs_enabled, .term_enabled, .dll_reset_needed, .bank_open, .refresh_count);
   pdr_ctl_model pdr_ctl_model_inst (.clk_sys, .cke_pin, .reset_pin_n, .odt_pin, .cmd, .bank_addr,
      .addr, .mr_sel);
   // ======================
   // Shared tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait: pin path adds several cycles of latency
   task automatic wait_state(input pdr_state_t exp);
      int n;
      n = 0;
      while (state !== exp && n < 24)
      begin
         @(negedge clk_sys);
         n++;
      end
      check(16'(state), 16'(exp));
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ======================
   // Scenarios
   task automatic t_reset();
      repeat (6) @(negedge clk_sys);
      check(16'(state), 16'(pdr_st_reset));
      check(refresh_count, 16'h0);
      resetn = 1'b1;
      wait_state(pdr_st_run);
      check({12'h0, outputs_enabled, buffers_on, dll_on, term_enabled}, 16'hf);
      $display("test reset done");
   endtask
   task automatic t_slow();
      ce = 1'b0;
      pdr_ctl_model_inst.issue(4'h1, 3'h0, 13'h0, 1); // frozen, must not count
      check(refresh_count, 16'h0);
      ce = 1'b1;
      pdr_ctl_model_inst.issue(4'h1, 3'h0, 13'h0, 1);
      check(refresh_count, 16'h1);
      pdr_ctl_model_inst.enter_pd();
      wait_state(pdr_st_pre_slow);
      @(negedge clk_sys);
      check({12'h0, in_power_down, dll_on, odt_async, buffers_on}, 16'ha);
      check(16'(outputs_enabled), 16'h0);
      pdr_ctl_model_inst.exit_pd();
      wait_state(pdr_st_run);
      $display("test slow exit done");
   endtask
   task automatic t_fast();
      pdr_ctl_model_inst.issue(4'h0, 3'h0, 13'h1000, 12);
      pdr_ctl_model_inst.enter_pd();
      wait_state(pdr_st_pre_fast);
      check({13'h0, in_power_down, dll_on, odt_async}, 16'h6);
      pdr_ctl_model_inst.exit_pd();
      wait_state(pdr_st_run);
      $display("test fast exit done");
   endtask
   task automatic t_active();
      pdr_ctl_model_inst.issue(4'h3, 3'h3, 13'h0, 1);
      pdr_ctl_model_inst.issue(4'h3, 3'h5, 13'h0, 1);
      check(16'(bank_open), 16'h28);
      pdr_ctl_model_inst.issue(4'h2, 3'h3, 13'h0, 1); // single bank close
      check(16'(bank_open), 16'h20);
      pdr_ctl_model_inst.issue(4'h2, 3'h0, 13'h0400, 1); // close all
      check(16'(bank_open), 16'h0);
      pdr_ctl_model_inst.issue(4'h3, 3'h3, 13'h0, 1);
      pdr_ctl_model_inst.write_then_wait(3'h3, 1'b0, 1'b0);
      check(16'(bank_open), 16'h8);
      pdr_ctl_model_inst.enter_pd();
      wait_state(pdr_st_act_pd);
      pdr_ctl_model_inst.issue(4'h3, 3'h5, 13'h0, 1); // ignored while powered down
      check({6'h0, in_power_down, dll_on, bank_open}, 16'h308);
      $display("test active power-down done");
   endtask
   task automatic t_pin_reset();
      fork
         pdr_ctl_model_inst.pin_reset();
         begin
            wait_state(pdr_st_reset);
            check({12'h0, outputs_enabled, term_enabled, in_power_down, dll_reset_needed}, 16'h1);
            check({bank_open, refresh_count[7:0]}, 16'h0001);
         end
      join
      pdr_ctl_model_inst.exit_pd();
      wait_state(pdr_st_run);
      pdr_ctl_model_inst.issue(4'h0, 3'h0, 13'h0100, 1); // DLL reset after exit
      check(16'(dll_reset_needed), 16'h0);
      $display("test pin reset done");
   endtask
   initial
   begin
      t_reset();
      t_slow();
      t_fast();
      t_active();
      t_pin_reset();
      report_and_stop();
   end
   // Watchdog, well beyond the roughly 160 cycles the tests need
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
